//--- hdl/sldd_decode.sv
// Second-level directory entry decoder with walk permission accumulation
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
`timescale 1ns/10ps

module sldd_decode
    import sldd_pkg::*;
#(
    parameter int host_address_width = DefaultHostAddrWidth,
    parameter bit snoopControlCap = 1'b0
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Request
    input wire logic reqValid,
    input sldd_req_s req,
    input sldd_cfg_s cfg,
    // Result
    output logic rspValid,
    output sldd_rsp_s rsp
);

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    function automatic logic memTypeReserved(input logic [2:0] code);
        unique case (code)
            MemUc, MemWc, MemWt, MemWp, MemWb: memTypeReserved = 1'b0;
            default: memTypeReserved = 1'b1;
        endcase
    endfunction

    function automatic logic [63:0] addrMask(input int lo);
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < 64; i++)
        begin
            if (i >= lo && i < host_address_width)
            begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    localparam logic [63:0] LargeMask = addrMask(LargeAddrLo);
    localparam logic [63:0] TableMask = addrMask(TableAddrLo);

    // -------------------------------------------------------------------------
    // Combinational decode
    // -------------------------------------------------------------------------
    sldd_rsp_s rspD;
    logic rspValidD;
    logic accReadQ, accWriteQ, accExecQ;
    logic accReadD, accWriteD, accExecD;
    logic [63:0] e;
    logic isLarge;
    logic extOn;
    logic rsvdHit;
    logic pRead, pWrite, pExec;
    logic readCheck;

    always_comb
    begin
        e = req.entry;
        rsvdHit = 1'b0;
        // Large page only when supported; otherwise bit 7 is a reserved fault
        isLarge = e[BitPageSize] && cfg.large_page_support;
        if (e[BitPageSize] && !cfg.large_page_support)
        begin
            rsvdHit = 1'b1;
        end
        extOn = cfg.ext_memory_type_enable && (cfg.table_mode_select != TableModeLegacy);
        // Common reserved bits: 62 and 51 down to the address width
        if (e[BitRsvd62])
        begin
            rsvdHit = 1'b1;
        end
        for (int i = 0; i <= ReservedHi; i++)
        begin
            if (i >= host_address_width && e[i])
            begin
                rsvdHit = 1'b1;
            end
        end
        if (isLarge)
        begin
            // Bits 20:12 reserved in the large-page form
            for (int i = TableAddrLo; i < LargeAddrLo; i++)
            begin
                if (e[i])
                begin
                    rsvdHit = 1'b1;
                end
            end
            if (!snoopControlCap && e[BitSnoop])
            begin
                rsvdHit = 1'b1;
            end
        end
        else if (e[BitSnoop])
        begin
            rsvdHit = 1'b1;
        end

        // Entry-level permissions; execute only enforced when enabled
        pRead = e[BitRead];
        pWrite = e[BitWrite];
        pExec = e[BitExec] || !cfg.execute_enforce_enable;

        // Walk accumulation restarts on the first entry of a walk
        accReadD = req.firstLevel ? pRead : (accReadQ && pRead);
        accWriteD = req.firstLevel ? pWrite : (accWriteQ && pWrite);
        accExecD = req.firstLevel ? pExec : (accExecQ && pExec);
        if (!reqValid)
        begin
            accReadD = accReadQ;
            accWriteD = accWriteQ;
            accExecD = accExecQ;
        end

        // Zero-length reads bypass the read check when write or execute is granted
        readCheck = req.wantRead;
        if (cfg.zero_length_read_cap && req.zeroLength && (accWriteD || accExecD))
        begin
            readCheck = 1'b0;
        end

        rspD = '0;
        rspD.isLargePage = isLarge;
        rspD.addr = isLarge ? (e & LargeMask) : (e & TableMask);
        rspD.permRead = accReadD;
        rspD.permWrite = accWriteD;
        rspD.permExec = accExecD;
        rspD.transFault = (readCheck && !accReadD) || (req.wantWrite && !accWriteD)
            || (req.wantExec && !accExecD);

        // Memory type applies only for second-level-only or nested from coherent devices
        if (isLarge && extOn && cfg.coherentDevice
            && (cfg.translation_type == XlateSecondOnly || cfg.translation_type == XlateNested))
        begin
            rspD.memTypeValid = 1'b1;
            rspD.memType = e[ExtTypeHi:ExtTypeLo];
            if (memTypeReserved(e[ExtTypeHi:ExtTypeLo]))
            begin
                rspD.memTypeValid = 1'b0;
                rsvdHit = 1'b1;
            end
        end
        else
        begin
            rspD.memType = ResetMemType;
        end

        // Attribute table used by default; bit 6 only counts for nested PASID coherent requests
        rspD.useAttrTable = 1'b1;
        if (isLarge && extOn && cfg.coherentDevice && cfg.withPasid && cfg.translation_type == XlateNested)
        begin
            rspD.useAttrTable = !e[BitIgnAttr];
        end

        rspD.accessedSeen = cfg.access_dirty_enable && e[BitAccessed];
        rspD.rsvdFault = rsvdHit;
        rspValidD = reqValid;
        // Result holds between requests
        if (!reqValid)
        begin
            rspD = rsp;
        end
    end

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            rspValid <= 1'b0;
            rsp <= '0;
            accReadQ <= 1'b1;
            accWriteQ <= 1'b1;
            accExecQ <= 1'b1;
        end
        else
        begin
            rspValid <= rspValidD;
            rsp <= rspD;
            accReadQ <= accReadD;
            accWriteQ <= accWriteD;
            accExecQ <= accExecD;
        end
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    a_large_select: assert property (@(posedge clock) disable iff (reset)
        reqValid |=> rspValid && rsp.isLargePage == $past(req.entry[BitPageSize] && cfg.large_page_support))
        else $error("page size decode wrong");
    a_ps_reserved: assert property (@(posedge clock) disable iff (reset)
        reqValid && req.entry[BitPageSize] && !cfg.large_page_support |=> rsp.rsvdFault && !rsp.isLargePage)
        else $error("unsupported page size not faulted");
    a_write_deny: assert property (@(posedge clock) disable iff (reset)
        reqValid && !req.entry[BitWrite] && req.wantWrite |=> !rsp.permWrite && rsp.transFault)
        else $error("write not denied");
    a_read_deny: assert property (@(posedge clock) disable iff (reset)
        reqValid && !req.entry[BitRead] && req.wantRead && !req.zeroLength |=> rsp.transFault)
        else $error("read not denied");
    a_exec_deny: assert property (@(posedge clock) disable iff (reset)
        reqValid && cfg.execute_enforce_enable && !req.entry[BitExec] |=> !rsp.permExec)
        else $error("execute not denied");
    a_zero_len_skip: assert property (@(posedge clock) disable iff (reset)
        reqValid && req.firstLevel && cfg.zero_length_read_cap && req.zeroLength && req.entry[BitWrite]
        && req.wantRead && !req.wantWrite && !req.wantExec |=> !rsp.transFault)
        else $error("zero-length read faulted");
    a_table_addr: assert property (@(posedge clock) disable iff (reset)
        reqValid && !req.entry[BitPageSize] |=> rsp.addr == ($past(req.entry) & TableMask))
        else $error("table address wrong");
    a_page_addr: assert property (@(posedge clock) disable iff (reset)
        reqValid && req.entry[BitPageSize] && cfg.large_page_support
        |=> rsp.addr == ($past(req.entry) & LargeMask))
        else $error("page address wrong");
    a_walk_and: assert property (@(posedge clock) disable iff (reset)
        reqValid && !req.entry[BitRead] ##1 reqValid && !req.firstLevel && req.entry[BitRead] |=> !rsp.permRead)
        else $error("walk permission not accumulated");
    a_accessed_off: assert property (@(posedge clock) disable iff (reset)
        reqValid && !cfg.access_dirty_enable |=> !rsp.accessedSeen)
        else $error("accessed bit not ignored");
    a_memtype_reserved: assert property (@(posedge clock) disable iff (reset)
        rspValid && rsp.memTypeValid |-> !memTypeReserved(rsp.memType))
        else $error("reserved memory type reported");
    a_attr_default: assert property (@(posedge clock) disable iff (reset)
        reqValid && cfg.table_mode_select == TableModeLegacy |=> rsp.useAttrTable && !rsp.memTypeValid)
        else $error("legacy mode used entry memory attributes");

endmodule

//--- hdl/sldd_pkg.sv
// Package for the second-level directory entry decoder
package sldd_pkg;

    // Entry field positions
    localparam int BitRead = 0;
    localparam int BitWrite = 1;
    localparam int BitExec = 2;
    localparam int ExtTypeLo = 3;
    localparam int ExtTypeHi = 5;
    localparam int BitIgnAttr = 6;
    localparam int BitPageSize = 7;
    localparam int BitAccessed = 8;
    localparam int BitSnoop = 11;
    localparam int LargeAddrLo = 21;
    localparam int TableAddrLo = 12;
    localparam int ReservedHi = 51;
    localparam int BitRsvd62 = 62;
    localparam int DefaultHostAddrWidth = 48;

    // Mode encodings
    localparam logic [1:0] TableModeLegacy = 2'h0;
    localparam logic [2:0] XlateSecondOnly = 3'h2;
    localparam logic [2:0] XlateNested = 3'h3;

    // Memory type codes
    localparam logic [2:0] MemUc = 3'h0;
    localparam logic [2:0] MemWc = 3'h1;
    localparam logic [2:0] MemWt = 3'h4;
    localparam logic [2:0] MemWp = 3'h5;
    localparam logic [2:0] MemWb = 3'h6;

    // Reset values
    localparam logic [63:0] ResetAddr = 64'h0;
    localparam logic [2:0] ResetMemType = 3'h0;

    // Request to the decoder
    typedef struct packed {
        logic [63:0] entry;
        logic firstLevel;
        logic wantRead;
        logic wantWrite;
        logic wantExec;
        logic zeroLength;
    } sldd_req_s;

    // Governing PASID-entry and capability settings
    typedef struct packed {
        logic ext_memory_type_enable;
        logic [1:0] table_mode_select;
        logic [2:0] translation_type;
        logic execute_enforce_enable;
        logic access_dirty_enable;
        logic zero_length_read_cap;
        logic large_page_support;
        logic coherentDevice;
        logic withPasid;
    } sldd_cfg_s;

    // Decoded result
    typedef struct packed {
        logic isLargePage;
        logic [63:0] addr;
        logic permRead;
        logic permWrite;
        logic permExec;
        logic transFault;
        logic rsvdFault;
        logic memTypeValid;
        logic [2:0] memType;
        logic useAttrTable;
        logic accessedSeen;
    } sldd_rsp_s;

endpackage

//--- tb/sldd_decode_test.sv
// Self-checking bench for the directory entry decoder
`timescale 1ns/10ps

module sldd_decode_test;
    import sldd_pkg::*;

    // Narrow address width so the reserved span above it gets exercised
    localparam int AddrW = 40;
    localparam int CfgW = $bits(sldd_cfg_s);

    logic clock;
    logic reset;
    logic reqValid;
    logic [4:0] ctl;
    logic [4:0] nctl;
    sldd_cfg_s cfg;
    sldd_cfg_s nc;
    logic wrEn;
    logic [3:0] wrIdx;
    logic [63:0] wrData;
    logic [3:0] rdIdx;
    logic [63:0] memData;
    sldd_req_s req;
    logic rspValid;
    sldd_rsp_s rsp;
    sldd_rsp_s got;
    sldd_rsp_s expQ[$];
    logic [63:0] tbl [16];
    logic [2:0] acc;
    int fails;
    int total_checks;

    assign req = {memData, ctl};

    sldd_table_mem MEM (.clock(clock), .wrEn(wrEn), .wrIdx(wrIdx), .wrData(wrData), .rdIdx(rdIdx), .rdData(memData));

    sldd_decode #(.host_address_width(AddrW)) DUT (.clock(clock), .reset(reset), .reqValid(reqValid), .req(req),
        .cfg(cfg), .rspValid(rspValid), .rsp(rsp));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
        total_checks++;
        if (g !== x)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic finish_test();
        $display("Checks made %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Reference decode of one entry c = {firstLevel, wantRead, wantWrite, wantExec, zeroLength}
    task automatic predict(input logic [63:0] e, input logic [4:0] c);
        sldd_rsp_s x;
        logic [63:0] hi;
        logic mt;
        logic byp;
        x = '0;
        hi = (64'h1 << AddrW) - 64'h1;
        x.isLargePage = e[7] & nc.large_page_support;
        x.addr = e & hi & (x.isLargePage ? ~64'h1FFFFF : ~64'hFFF);
        if (c[4])
            acc = 3'h7;
        acc = acc & {e[2] | !nc.execute_enforce_enable, e[1], e[0]};
        {x.permExec, x.permWrite, x.permRead} = acc;
        byp = nc.zero_length_read_cap & c[0] & (acc[1] | acc[2]);
        x.transFault = (c[3] & !acc[0] & !byp) | (c[2] & !acc[1]) | (c[1] & !acc[2]);
        mt = x.isLargePage & nc.ext_memory_type_enable & (nc.table_mode_select != TableModeLegacy) & nc.coherentDevice
            & (nc.translation_type == XlateSecondOnly || nc.translation_type == XlateNested);
        x.memTypeValid = mt & (e[5:3] inside {MemUc, MemWc, MemWt, MemWp, MemWb});
        x.memType = mt ? e[5:3] : 3'h0;
        x.useAttrTable = (mt & nc.translation_type == XlateNested & nc.withPasid) ? !e[6] : 1'b1;
        x.accessedSeen = e[8] & nc.access_dirty_enable;
        x.rsvdFault = e[62] | |(e[51:0] & ~hi) | (e[7] & !nc.large_page_support) | e[11]
            | (x.isLargePage & |e[20:12]) | (mt & !x.memTypeValid);
        expQ.push_back(x);
    endtask

    // Result watcher: each pulse retires the oldest expectation
    always @(negedge clock)
    begin
        if (rspValid === 1'b1)
        begin
            if (expQ.size() == 0)
                chk("unexpected rspValid", 64'h0, 64'h1);
            else
            begin
                got = expQ.pop_front();
                chk("isLargePage", 64'(got.isLargePage), 64'(rsp.isLargePage));
                chk("addr", got.addr, rsp.addr);
                chk("perms", 64'({got.permExec, got.permWrite, got.permRead}),
                    64'({rsp.permExec, rsp.permWrite, rsp.permRead}));
                chk("transFault", 64'(got.transFault), 64'(rsp.transFault));
                chk("rsvdFault", 64'(got.rsvdFault), 64'(rsp.rsvdFault));
                chk("memType", 64'({got.memTypeValid, got.memType}),
                    64'({rsp.memTypeValid, rsp.memType}));
                chk("useAttrTable", 64'(got.useAttrTable), 64'(rsp.useAttrTable));
                chk("accessedSeen", 64'(got.accessedSeen), 64'(rsp.accessedSeen));
            end
        end
    end

    initial
    begin
        #200000;
        fails++;
        finish_test();
    end

    initial
    begin
        reset = 1'b1;
        reqValid = 1'b0;
        ctl = '0;
        cfg = '0;
        nc = '0;
        wrEn = 1'b0;
        wrIdx = '0;
        wrData = '0;
        rdIdx = '0;
        acc = 3'h7;
        fails = 0;
        total_checks = 0;
        void'($urandom(32'hC6A9));
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        chk("rsp at reset", 64'h0, 64'({rspValid, |rsp}));
        // Mostly clean entries, with one in four keeping its reserved bits
        for (int i = 0; i < 16; i++)
        begin
            tbl[i] = {$urandom, $urandom};
            if ($urandom_range(3) != 0)
                tbl[i] = tbl[i] & 64'hBFF0_00FF_FFFF_F7FF & (tbl[i][7] ? ~64'h1F_F000 : ~64'h0);
            @(posedge clock);
            wrEn <= 1'b1;
            wrIdx <= 4'(i);
            wrData <= tbl[i];
        end
        @(posedge clock);
        wrEn <= 1'b0;
        for (int n = 0; n < 600; n++)
        begin
            @(posedge clock);
            if ($urandom_range(3) == 0)
                reqValid <= 1'b0;
            else
            begin
                nc = CfgW'($urandom);
                rdIdx <= 4'(n % 16);
                // Same control word goes to the design and to the prediction
                nctl = {n == 0 || $urandom_range(2) == 0, 4'($urandom)};
                ctl <= nctl;
                predict(tbl[n % 16], nctl);
                cfg <= nc;
                reqValid <= 1'b1;
            end
        end
        @(posedge clock);
        reqValid <= 1'b0;
        for (int k = 0; k < 10 && expQ.size() != 0; k++)
            @(posedge clock);
        chk("pending results", 64'h0, 64'(expQ.size()));
        finish_test();
    end
endmodule

//--- tb/sldd_table_mem.sv
// Page-table memory model that hands directory entries to the decoder
`timescale 1ns/10ps

module sldd_table_mem
(
    // Clock
    input wire logic clock,
    // Table load
    input wire logic wrEn,
    input wire logic [3:0] wrIdx,
    input wire logic [63:0] wrData,
    // Entry fetch
    input wire logic [3:0] rdIdx,
    output logic [63:0] rdData
);
    logic [63:0] mem [16];

    always_ff @(posedge clock)
    begin
        if (wrEn)
        begin
            mem[wrIdx] <= wrData;
        end
    end

    // Immediate read, so a fetched entry arrives in its request cycle
    assign rdData = mem[rdIdx];
endmodule
